//--- asd_pkg.sv
// Package for the scan mask and diagnostics register block.
// Assumes word-addressed Avalon-MM access; register indices map to byte address = 4 * index.
package asd_pkg;
  // Register indices (byte address is four times the index)
  localparam logic [7:0] ASD_IDX_SCAN_MODE = 8'h10;
  localparam logic [7:0] ASD_IDX_SCAN_MASK = 8'h12;
  localparam logic [7:0] ASD_IDX_UNLOCK_KEY = 8'hbf;
  localparam logic [7:0] ASD_IDX_DIAGNOSTICS_ACTIVE = 8'hc0;
  localparam logic [7:0] ASD_IDX_PAT_LOW = 8'hc1;
  localparam logic [7:0] ASD_IDX_PAT_HIGH = 8'hc2;
  localparam logic [7:0] ASD_IDX_SCAN_STATUS = 8'h13;
  // Field positions and values
  localparam int ASD_BIT_WALK = 0;
  localparam int ASD_BIT_VTEST = 4;
  localparam int ASD_BIT_SCAN_RUN = 4;
  localparam logic [7:0] ASD_DIAGNOSTICS_ACTIVE_MASK = 8'h11;
  localparam logic [7:0] ASD_SCAN_MODE_MASK = 8'h13;
  localparam logic [1:0] ASD_MODE_AUTO = 2'h1;
  localparam logic [7:0] ASD_UNLOCK_VALUE = 8'h96;
  localparam logic [7:0] ASD_RESET_VALUE = 8'h00;
  // Time spent on each scanned channel
  localparam int ASD_CONV_NS = 1000;
  localparam int ASD_CLK_NS = 4;
  localparam int ASD_CONV_CYCLES = ASD_CONV_NS / ASD_CLK_NS;
  // Scan engine states
  typedef enum logic [1:0] {
    ASD_IDLE = 2'b00,
    ASD_SEEK = 2'b01,
    ASD_CONV = 2'b11
  } asd_state_t;
endpackage : asd_pkg

//--- asd_regs.sv
// Scan mask, scan run control and diagnostics registers with a small auto-scan walker.
// Assumes an Avalon-MM master on ref_clk with word addresses, and conversion logic outside
// that consumes the channel select, conversion strobe and diagnostic controls.
// Bus timing: a request seen with waitrequest high is taken at that edge,
// waitrequest then drops for exactly one cycle while read data and the
// response code stand. Waitrequest is kept in its own flop so that every
// output leaves the block straight from a register.
// The diagnostic controls lag their register by one cycle.
// The forced pattern is held at zero while bit-walk is off.
`timescale 1ns/10ps
module asd_regs #(
  parameter int NUM_CH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  output logic [7:0] scan_channel_mask,
  output logic scan_active,
  output logic [2:0] scan_channel,
  output logic conv_start,
  output logic test_voltage_select,
  output logic decision_force_enable,
  output logic diagnostics_active,
  output logic [15:0] forced_pattern
);

  // Refuse every channel count other than the eight the eight-bit mask serves
  if (NUM_CH != 8) begin : g_bad_num_ch
    $error("asd_regs supports eight channels only");
  end

  logic [7:0] scan_cfg_q;
  logic [7:0] mask_q;
  logic [7:0] key_q;
  logic [7:0] diagnostics_active_q;
  logic [7:0] pat_low_q;
  logic [7:0] pat_high_q;
  logic ack_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;
  logic [7:0] rdata_d;
  logic hit_d;
  logic unlocked;
  logic wr_ok;
  asd_pkg::asd_state_t state_q;
  logic [2:0] ch_q;
  logic [8:0] cnt_q;
  logic start_q;

  // Strobe is accepted when a write is pending, not yet answered and byte lane 0 is enabled
  assign wr_ok = avs_write && !ack_q && avs_byteenable[0];
  assign unlocked = (key_q == asd_pkg::ASD_UNLOCK_VALUE);

  // Address decode for reads and response code
  always_comb begin
    rdata_d = 8'h00;
    hit_d = 1'b1;
    unique case (avs_address)
      asd_pkg::ASD_IDX_SCAN_MODE: rdata_d = scan_cfg_q;
      asd_pkg::ASD_IDX_SCAN_MASK: rdata_d = mask_q;
      asd_pkg::ASD_IDX_UNLOCK_KEY: rdata_d = key_q;
      asd_pkg::ASD_IDX_DIAGNOSTICS_ACTIVE: rdata_d = diagnostics_active_q;
      asd_pkg::ASD_IDX_PAT_LOW: rdata_d = pat_low_q;
      asd_pkg::ASD_IDX_PAT_HIGH: rdata_d = pat_high_q;
      asd_pkg::ASD_IDX_SCAN_STATUS: rdata_d = {4'h0, scan_active, ch_q};
      default: hit_d = 1'b0;
    endcase
  end

  // One wait cycle, then answer for one cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
      resp_q <= 2'h0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
      wait_q <= !((avs_read || avs_write) && !ack_q); // Low only in the answer cycle
      if ((avs_read || avs_write) && !ack_q) begin
        rdata_q <= avs_read ? {24'h000000, rdata_d} : 32'h00000000;
        resp_q <= hit_d ? 2'h0 : 2'h3;
      end
    end
  end

  // Scan configuration and mask, always writable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scan_cfg_q <= asd_pkg::ASD_RESET_VALUE;
      mask_q <= asd_pkg::ASD_RESET_VALUE;
      key_q <= asd_pkg::ASD_RESET_VALUE;
    end else if (wr_ok) begin
      if (avs_address == asd_pkg::ASD_IDX_SCAN_MODE)
        scan_cfg_q <= avs_writedata[7:0] & asd_pkg::ASD_SCAN_MODE_MASK;
      if (avs_address == asd_pkg::ASD_IDX_SCAN_MASK)
        mask_q <= avs_writedata[7:0];
      if (avs_address == asd_pkg::ASD_IDX_UNLOCK_KEY)
        key_q <= avs_writedata[7:0];
    end
  end

  // Diagnostics group writable only while unlocked
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      diagnostics_active_q <= asd_pkg::ASD_RESET_VALUE;
      pat_low_q <= asd_pkg::ASD_RESET_VALUE;
      pat_high_q <= asd_pkg::ASD_RESET_VALUE;
    end else if (wr_ok && unlocked) begin
      if (avs_address == asd_pkg::ASD_IDX_DIAGNOSTICS_ACTIVE)
        diagnostics_active_q <= avs_writedata[7:0] & asd_pkg::ASD_DIAGNOSTICS_ACTIVE_MASK;
      if (avs_address == asd_pkg::ASD_IDX_PAT_LOW)
        pat_low_q <= avs_writedata[7:0];
      if (avs_address == asd_pkg::ASD_IDX_PAT_HIGH)
        pat_high_q <= avs_writedata[7:0];
    end
  end

  // Registered diagnostic controls toward the converter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      decision_force_enable <= 1'b0;
      test_voltage_select <= 1'b0;
      diagnostics_active <= 1'b0;
      forced_pattern <= 16'h0000;
    end else begin
      decision_force_enable <= diagnostics_active_q[asd_pkg::ASD_BIT_WALK];
      test_voltage_select <= diagnostics_active_q[asd_pkg::ASD_BIT_VTEST]
        && !diagnostics_active_q[asd_pkg::ASD_BIT_WALK];
      diagnostics_active <= diagnostics_active_q[asd_pkg::ASD_BIT_WALK];
      if (diagnostics_active_q[asd_pkg::ASD_BIT_WALK])
        forced_pattern <= {pat_high_q, pat_low_q};
      else
        forced_pattern <= 16'h0000;
    end
  end

  // Auto-scan walker: ascending over enabled channels while run is set
  logic run;
  logic [2:0] nxt;
  logic found;
  assign run = scan_cfg_q[asd_pkg::ASD_BIT_SCAN_RUN]
    && (scan_cfg_q[1:0] == asd_pkg::ASD_MODE_AUTO) && (mask_q != 8'h00);
  always_comb begin
    nxt = 3'h0;
    found = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (mask_q[i] && (3'(i) >= ch_q)) begin
        nxt = 3'(i);
        found = 1'b1;
      end
    end
    if (!found) begin
      for (int i = 7; i >= 0; i--) begin
        if (mask_q[i]) nxt = 3'(i);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= asd_pkg::ASD_IDLE;
      ch_q <= 3'h0;
      cnt_q <= 9'h000;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      unique case (state_q)
        asd_pkg::ASD_IDLE: begin
          ch_q <= 3'h0;
          if (run) state_q <= asd_pkg::ASD_SEEK;
        end
        asd_pkg::ASD_SEEK: begin
          if (!run) begin
            state_q <= asd_pkg::ASD_IDLE;
          end else begin
            ch_q <= nxt;
            start_q <= 1'b1;
            cnt_q <= 9'(asd_pkg::ASD_CONV_CYCLES - 1);
            state_q <= asd_pkg::ASD_CONV;
          end
        end
        asd_pkg::ASD_CONV: begin
          if (!run) begin
            state_q <= asd_pkg::ASD_IDLE;
          end else if (cnt_q == 9'h000) begin
            ch_q <= ch_q + 3'h1;
            state_q <= asd_pkg::ASD_SEEK;
          end else begin
            cnt_q <= cnt_q - 9'h001;
          end
        end
        default: state_q <= asd_pkg::ASD_IDLE;
      endcase
    end
  end

  // Outputs straight from flip-flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scan_channel_mask <= 8'h00;
      scan_active <= 1'b0;
      scan_channel <= 3'h0;
      conv_start <= 1'b0;
    end else begin
      scan_channel_mask <= mask_q;
      scan_active <= (state_q != asd_pkg::ASD_IDLE);
      scan_channel <= ch_q;
      conv_start <= start_q;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign avs_response = resp_q;

endmodule : asd_regs

//--- asd_regs_props.sv
// Checker for the scan mask and diagnostics register block.
// Sees only the ports of asd_regs; one clock, reset active high.
`timescale 1ns/10ps
module asd_regs_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic [7:0] scan_channel_mask,
  input wire logic scan_active,
  input wire logic [2:0] scan_channel,
  input wire logic conv_start,
  input wire logic test_voltage_select,
  input wire logic decision_force_enable,
  input wire logic diagnostics_active,
  input wire logic [15:0] forced_pattern
);
  logic [7:0] key_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Mirror of the unlock key as taken from the bus
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      key_q <= 8'h00;
    end else if (avs_write && avs_waitrequest && avs_byteenable[0] && avs_address == 8'hbf) begin
      key_q <= avs_writedata[7:0];
    end
  end
  // A write taken at one register
  sequence wr_to(logic [7:0] a);
    avs_write && avs_waitrequest && avs_byteenable[0] && avs_address == a;
  endsequence
  ack_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  mask_copy_a: assert property (wr_to(8'h12) |-> ##2 scan_channel_mask == $past(avs_writedata[7:0], 2))
    else $error("scan mask output does not follow the write");
  unlock_wr_a: assert property (wr_to(8'hc0) ##0 key_q == 8'h96 |-> ##2
    decision_force_enable == $past(avs_writedata[0], 2))
    else $error("unlocked diagnostics write not applied");
  vtest_on_a: assert property (wr_to(8'hc0) ##0 key_q == 8'h96 |-> ##2
    test_voltage_select == ($past(avs_writedata[4], 2) && !$past(avs_writedata[0], 2)))
    else $error("test voltage select wrong after write");
  lock_hold_a: assert property (wr_to(8'hc0) ##0 key_q != 8'h96 |=> ##1
    $stable(decision_force_enable) && $stable(test_voltage_select))
    else $error("locked diagnostics write changed outputs");
  walk_diag_a: assert property (diagnostics_active == decision_force_enable)
    else $error("diagnostics active differs from walk enable");
  pat_zero_a: assert property (!diagnostics_active |-> forced_pattern == 16'h0000)
    else $error("forced pattern applied while diagnostics idle");
  conv_mask_a: assert property (conv_start |-> scan_channel_mask[scan_channel])
    else $error("conversion started on a masked channel");
  conv_run_a: assert property (conv_start |-> scan_active)
    else $error("conversion started while scan stopped");
endmodule : asd_regs_props

//--- asd_host.sv
// Host model: Avalon-MM master that reaches the register map.
// Assumes a slave that answers by lowering waitrequest.
`timescale 1ns/10ps
module asd_host (
  input wire logic ref_clk,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response
);
  // Idle bus at time zero
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h1;
  end
  // One transfer: hold until waitrequest low, then release and scramble data
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
                      output logic [1:0] r);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    q = avs_readdata[7:0];
    r = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    avs_writedata <= ~avs_writedata;
    @(posedge ref_clk);
  endtask : xfer
endmodule : asd_host

//--- asd_regs_tb.sv
// Testbench for asd_regs driven through the host model.
// Assumes asd_pkg and asd_host are compiled first.
`timescale 1ns/10ps
module asd_regs_tb;
  logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, scan_active, conv_start;
  logic test_voltage_select, decision_force_enable, diagnostics_active;
  logic [7:0] avs_address, scan_channel_mask, q;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [1:0] avs_response, r;
  logic [2:0] scan_channel;
  logic [15:0] forced_pattern;
  logic [7:0] regs [5] = '{8'h12, 8'hbf, 8'hc0, 8'hc1, 8'hc2};
  logic [2:0] seen [$];
  int err_count = 0, compares = 0, cyc = 0;
  asd_regs i_dut (.*);
  asd_host i_host (.*);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Channel of every conversion start
  always @(negedge ref_clk) if (conv_start === 1'b1) seen.push_back(scan_channel);
  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.xfer(1'b1, a, d, q, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    i_host.xfer(1'b0, a, 8'h00, q, r);
    chk($sformatf("read %h", a), e, q);
    chk($sformatf("response %h", a), er, r);
  endtask : rd
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    foreach (regs[i]) rd(regs[i], 8'h00, 2'h0);
    $display("reset values done");
    wr(8'hc0, 8'h11);
    wr(8'hc1, 8'ha5);
    rd(8'hc0, 8'h00, 2'h0);
    rd(8'hc1, 8'h00, 2'h0);
    wr(8'hbf, 8'h96);
    rd(8'hbf, 8'h96, 2'h0);
    wr(8'hc0, 8'hf0);
    rd(8'hc0, 8'h10, 2'h0);
    chk("test select", 16'h1, test_voltage_select);
    chk("pattern idle", 16'h0, forced_pattern);
    wr(8'hc1, 8'h5a);
    wr(8'hc2, 8'hc3);
    wr(8'hc0, 8'h11);
    chk("test select walk", 16'h0, test_voltage_select);
    chk("walk", 16'h1, decision_force_enable);
    chk("pattern", 16'hc35a, forced_pattern);
    wr(8'hbf, 8'h00);
    wr(8'hc0, 8'h00);
    chk("walk locked", 16'h1, decision_force_enable);
    $display("diagnostics done");
    wr(8'h12, 8'h29);
    chk("mask", 16'h29, scan_channel_mask);
    wr(8'h10, 8'h11);
    repeat (3 * asd_pkg::ASD_CONV_CYCLES + 20) @(posedge ref_clk);
    chk("starts", 16'h1, seen.size() >= 3);
    if (seen.size() >= 3) begin
      chk("first", 16'h0, seen[0]);
      chk("second", 16'h3, seen[1]);
      chk("third", 16'h5, seen[2]);
    end
    wr(8'h10, 8'h01);
    repeat (3) @(posedge ref_clk);
    chk("scan stopped", 16'h0, scan_active);
    rd(8'h10, 8'h01, 2'h0);
    rd(8'h13, 8'h00, 2'h0);
    wr(8'h10, 8'h10);
    repeat (3) @(posedge ref_clk);
    chk("manual no scan", 16'h0, scan_active);
    rd(8'h55, 8'h00, 2'h3);
    $display("scan done");
    give_verdict();
  end
endmodule : asd_regs_tb
bind asd_regs asd_regs_props i_props (.*);
